// ---- hdl/htq_bus_if.sv ----
// parallel register bus joining the host end to the queue manager device end
`default_nettype none
interface htq_bus_if;
  logic                        req;
  logic                        we;
  logic [htq_pkg::ADDR_W-1:0]  addr;
  logic [htq_pkg::DATA_W-1:0]  wdata;
  logic [htq_pkg::DATA_W-1:0]  rdata;
  logic                        ack;
  logic                        irq;

  modport dev  (input req, input we, input addr, input wdata, output rdata, output ack, output irq);
  modport host (output req, output we, output addr, output wdata, input rdata, input ack, input irq);
endinterface
`default_nettype wire

// ---- hdl/htq_device.sv ----
// queue manager device end: transmit control, free memory, enqueue, space request, queue data port
// Functional notes
// - tx control bit3 flow control, bit2 padding
// - tx control bit1 crc, bit0 transmit enable
// - tx control holds checksum generation enables
// - report free transmit memory in bytes, 6 KB
// - enqueue bit queues prepared frame, one only
// - enqueue bit self-clears after send; host waits
// - space request raises status bit6, self-clears
// - host writes needed space in double words
// - rx command bit3 starts queue data DMA
// - pointer bit14 auto-increments on data access
// - enable bit14 gates transmit-complete interrupt
// - enable bit6 gates space-available interrupt
// - status bits clear when written one
// - DMA write starts control then byte count
// - host pads frame data to double words
// - rx entry: status, count, then data
// - rx data includes crc, at most 2000
// - big-endian mode swaps header word bytes
// - control bit15 interrupt request, bits5-0 id
// - byte count bits10-0, correct and nonzero
//
// Decided for this implementation: the AXI4-Lite slave port.
`default_nettype none
module htq_device (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  htq_bus_if.dev                          bus,
  input  wire logic                       big_endian_pin,
  input  wire logic                       mac_tx_done,
  input  wire logic [htq_pkg::DATA_W-1:0] rx_status,
  input  wire logic [htq_pkg::DATA_W-1:0] rx_length,
  input  wire logic [htq_pkg::DATA_W-1:0] rx_data,
  output logic      [htq_pkg::DATA_W-1:0] tx_control,
  output logic                            tx_frame_valid,
  output logic      [htq_pkg::FID_W-1:0]  tx_frame_id,
  output logic      [htq_pkg::BC_W-1:0]   tx_byte_count,
  output logic                            rx_word_read
);
  import htq_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]        be_sync;
    logic [DATA_W-1:0] txctl;
    logic              enq;
    logic              space;
    logic [DATA_W-1:0] rxqc;
    logic [DATA_W-1:0] txptr;
    logic [DATA_W-1:0] interrupt_enable;
    logic [DATA_W-1:0] interrupt_status;
    logic [DATA_W-1:0] spreq;
    logic [FREE_W-1:0] free;
    logic [FREE_W-1:0] resv;
    logic [DATA_W-1:0] hctl;
    logic [DATA_W-1:0] hlen;
    logic [1:0]        rx_idx;
    logic [DATA_W-1:0] rdata;
    logic              ack;
    logic              irq;
    logic              rx_rd;
  } htq_dev_state_t;

  htq_dev_state_t r_reg;
  htq_dev_state_t r_next;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // header words move through the bus with their bytes exchanged in big-endian mode
  function automatic logic [DATA_W-1:0] order16(input logic [DATA_W-1:0] w, input logic be);
    order16 = be ? {w[7:0], w[15:8]} : w;
  endfunction

  // queue room one frame takes: header words plus data rounded up to double words
  function automatic logic [FREE_W-1:0] frame_room(input logic [BC_W-1:0] len);
    logic [FREE_W-1:0] l;
    l = {2'b00, len} + 13'h0003;
    frame_room = {l[FREE_W-1:2], 2'b00} + FRAME_HDR_BYTES;
  endfunction

  logic [FREE_W-1:0] room;
  logic [17:0]       need_bytes;
  logic [BC_W-1:0]   rx_len_clamped;
  logic              data_access;

  assign room           = frame_room(r_reg.hlen[BC_W-1:0]);
  assign need_bytes     = {r_reg.spreq, 2'b00};
  // the whole word is compared so that an oversized count cannot wrap below the limit
  assign rx_len_clamped = (rx_length > {5'h00, RX_MAX_BYTES}) ? RX_MAX_BYTES : rx_length[BC_W-1:0];
  assign data_access    = bus.req && (bus.addr == OFF_QUEUE_DATA) && r_reg.rxqc[RXQ_DMA_BIT];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next         = r_reg;
    r_next.ack     = bus.req;
    r_next.rx_rd   = 1'b0;
    r_next.be_sync = {r_reg.be_sync[0], big_endian_pin};

    // register writes
    if (bus.req && bus.we) begin
      unique case (bus.addr)
        OFF_TX_CONTROL:   r_next.txctl = bus.wdata;
        OFF_TX_QUEUE_CMD: begin
          // a second enqueue while one frame is pending is ignored
          if (bus.wdata[TXQ_ENQ_BIT] && !r_reg.enq) begin
            r_next.enq  = 1'b1;
            r_next.resv = room;
            r_next.free = r_reg.free - room;
          end
          if (bus.wdata[TXQ_SPACE_BIT]) begin
            r_next.space = 1'b1;
          end
        end
        OFF_RX_QUEUE_CMD: begin
          r_next.rxqc = bus.wdata;
          if (bus.wdata[RXQ_DMA_BIT] && !r_reg.rxqc[RXQ_DMA_BIT]) begin
            r_next.rx_idx = RX_IDX_STATUS;
          end
        end
        OFF_TX_DATA_PTR:  r_next.txptr = bus.wdata;
        OFF_INT_ENABLE:   r_next.interrupt_enable   = bus.wdata;
        OFF_INT_STATUS:   r_next.interrupt_status   = r_reg.interrupt_status & ~bus.wdata;
        OFF_TX_SPACE_REQ: r_next.spreq = bus.wdata;
        OFF_QUEUE_DATA: begin
          // only the two header words are kept; payload words are not stored
          if (r_reg.rxqc[RXQ_DMA_BIT]) begin
            if (r_reg.txptr[PTR_W-1:0] == HDR_CTL_PTR) begin
              r_next.hctl = order16(bus.wdata, r_reg.be_sync[1]);
            end else if (r_reg.txptr[PTR_W-1:0] == HDR_LEN_PTR) begin
              r_next.hlen = order16(bus.wdata, r_reg.be_sync[1]);
            end
          end
        end
        default: ;
      endcase
    end

    // register reads, data registered for the answer cycle
    if (bus.req && !bus.we) begin
      unique case (bus.addr)
        OFF_TX_CONTROL:   r_next.rdata = r_reg.txctl;
        OFF_TX_FREE_MEM:  r_next.rdata = {3'b000, r_reg.free};
        OFF_TX_QUEUE_CMD: r_next.rdata = {14'h0000, r_reg.space, r_reg.enq};
        OFF_RX_QUEUE_CMD: r_next.rdata = r_reg.rxqc;
        OFF_TX_DATA_PTR:  r_next.rdata = r_reg.txptr;
        OFF_INT_ENABLE:   r_next.rdata = r_reg.interrupt_enable;
        OFF_INT_STATUS:   r_next.rdata = r_reg.interrupt_status;
        OFF_TX_SPACE_REQ: r_next.rdata = r_reg.spreq;
        OFF_QUEUE_DATA: begin
          r_next.rdata = REG16_RESET;
          if (r_reg.rxqc[RXQ_DMA_BIT]) begin
            unique case (r_reg.rx_idx)
              RX_IDX_STATUS: r_next.rdata = order16(rx_status, r_reg.be_sync[1]);
              RX_IDX_LENGTH: r_next.rdata = order16({5'h00, rx_len_clamped}, r_reg.be_sync[1]);
              default: begin
                r_next.rdata = rx_data;
                r_next.rx_rd = 1'b1;
              end
            endcase
            if (r_reg.rx_idx != RX_IDX_DATA) begin
              r_next.rx_idx = r_reg.rx_idx + 2'h1;
            end
          end
        end
        default: r_next.rdata = REG16_RESET;
      endcase
    end

    // pointer steps on any queue data access while the DMA bit is set and auto-increment is on
    if (data_access && r_reg.txptr[PTR_AUTOINC]) begin
      r_next.txptr[PTR_W-1:0] = r_reg.txptr[PTR_W-1:0] + PTR_STEP;
    end

    // frame sent: release room, clear enqueue; set after clear so the event wins
    if (mac_tx_done && r_reg.enq) begin
      r_next.enq  = 1'b0;
      r_next.free = r_next.free + r_reg.resv;
      if (r_reg.hctl[CW_IC_BIT]) begin
        r_next.interrupt_status[INT_TX_BIT] = 1'b1;
      end
    end

    // space watch compares bytes against the double-word request
    if (r_reg.space && ({5'h00, r_reg.free} >= need_bytes)) begin
      r_next.interrupt_status[INT_SPACE_BIT] = 1'b1;
      r_next.space              = 1'b0;
    end

    r_next.irq = |(r_next.interrupt_status & r_next.interrupt_enable);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg      <= '0;
      r_reg.free <= TXQ_BYTES;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.rdata      = r_reg.rdata;
  assign bus.ack        = r_reg.ack;
  assign bus.irq        = r_reg.irq;
  assign tx_control     = r_reg.txctl;
  assign tx_frame_valid = r_reg.enq && r_reg.txctl[TXC_EN_BIT];
  assign tx_frame_id    = r_reg.hctl[FID_W-1:0];
  assign tx_byte_count  = r_reg.hlen[BC_W-1:0];
  assign rx_word_read   = r_reg.rx_rd;
endmodule
`default_nettype wire

// ---- hdl/htq_host.sv ----
// host end: AXI4-Lite command registers driving single transfers on the device bus
`default_nettype none
module htq_host (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  htq_bus_if.host                         bus,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [7:0]                 awaddr,
  input  wire logic [2:0]                 awprot,
  input  wire logic                       wvalid,
  output logic                            wready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  output logic                            bvalid,
  input  wire logic                       bready,
  output logic      [1:0]                 bresp,
  input  wire logic                       arvalid,
  output logic                            arready,
  input  wire logic [7:0]                 araddr,
  input  wire logic [2:0]                 arprot,
  output logic                            rvalid,
  input  wire logic                       rready,
  output logic      [31:0]                rdata,
  output logic      [1:0]                 rresp
);
  import htq_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HS_IDLE = 2'b01,
    HS_WAIT = 2'b10
  } htq_hstate_t;

  typedef struct packed {
    htq_hstate_t       st;
    logic              aw_hold;
    logic              w_hold;
    logic [7:0]        awa;
    logic [31:0]       wd;
    logic [3:0]        ws;
    logic              bv;
    logic [1:0]        br;
    logic              rv;
    logic [31:0]       rd;
    logic [1:0]        rr;
    logic [31:0]       cmd;
    logic [31:0]       wreg;
    logic [DATA_W-1:0] last_rd;
    logic              req;
  } htq_host_state_t;

  htq_host_state_t r_reg;
  htq_host_state_t r_next;

  // byte-lane merge used by both writable registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  logic unused_prot;
  assign unused_prot = ^{awprot, arprot};

  // ----------------------------------------------------------------
  // handshakes: one write and one read in flight at most
  // ----------------------------------------------------------------
  assign awready = !r_reg.aw_hold && !r_reg.bv;
  assign wready  = !r_reg.w_hold && !r_reg.bv;
  assign arready = !r_reg.rv;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    if (awvalid && awready) begin
      r_next.aw_hold = 1'b1;
      r_next.awa     = awaddr;
    end
    if (wvalid && wready) begin
      r_next.w_hold = 1'b1;
      r_next.wd     = wdata;
      r_next.ws     = wstrb;
    end
    if (r_reg.bv && bready) begin
      r_next.bv = 1'b0;
    end
    if (r_reg.rv && rready) begin
      r_next.rv = 1'b0;
    end

    // register write once address and data are both held
    if (r_reg.aw_hold && r_reg.w_hold) begin
      r_next.aw_hold = 1'b0;
      r_next.w_hold  = 1'b0;
      r_next.bv      = 1'b1;
      r_next.br      = RESP_OKAY;
      unique case (r_reg.awa)
        HOFF_CMD: begin
          // a launch while busy is dropped; software polls the busy bit first
          if (r_reg.st == HS_IDLE) begin
            r_next.cmd = merge(r_reg.cmd, r_reg.wd, r_reg.ws);
            if (r_reg.ws[3] && r_reg.wd[HCMD_GO_BIT]) begin
              r_next.req = 1'b1;
              r_next.st  = HS_WAIT;
            end
          end
        end
        HOFF_WDATA:  r_next.wreg = merge(r_reg.wreg, r_reg.wd, r_reg.ws);
        HOFF_STATUS: ;
        default:     r_next.br = RESP_SLVERR;
      endcase
    end

    // device transfer: request stands one cycle, answer taken on ack
    if (r_reg.req) begin
      r_next.req = 1'b0;
    end
    if (r_reg.st == HS_WAIT && bus.ack) begin
      r_next.st      = HS_IDLE;
      r_next.last_rd = bus.rdata;
    end

    // register read
    if (arvalid && arready) begin
      r_next.rv = 1'b1;
      r_next.rr = RESP_OKAY;
      unique case (araddr)
        HOFF_CMD:    r_next.rd = r_reg.cmd;
        HOFF_WDATA:  r_next.rd = r_reg.wreg;
        HOFF_STATUS: r_next.rd = {r_reg.last_rd, 14'h0000, bus.irq, r_reg.st == HS_WAIT};
        default: begin
          r_next.rd = REG32_RESET;
          r_next.rr = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg    <= '0;
      r_reg.st <= HS_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bvalid    = r_reg.bv;
  assign bresp     = r_reg.br;
  assign rvalid    = r_reg.rv;
  assign rdata     = r_reg.rd;
  assign rresp     = r_reg.rr;
  assign bus.req   = r_reg.req;
  assign bus.we    = r_reg.cmd[HCMD_WE_BIT];
  assign bus.addr  = r_reg.cmd[ADDR_W-1:0];
  assign bus.wdata = r_reg.wreg[DATA_W-1:0];
endmodule
`default_nettype wire

// ---- hdl/htq_pkg.sv ----
// constants shared by the host transmit queue manager device end and its host end
`default_nettype none
package htq_pkg;
  // ----------------------------------------------------------------
  // link widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  localparam int BC_W   = 11;
  localparam int FID_W  = 6;
  localparam int FREE_W = 13;
  localparam int PTR_W  = 11;

  // ----------------------------------------------------------------
  // device register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_TX_CONTROL   = 9'h170;
  localparam logic [ADDR_W-1:0] OFF_TX_FREE_MEM  = 9'h178;
  localparam logic [ADDR_W-1:0] OFF_TX_QUEUE_CMD = 9'h180;
  localparam logic [ADDR_W-1:0] OFF_RX_QUEUE_CMD = 9'h182;
  localparam logic [ADDR_W-1:0] OFF_TX_DATA_PTR  = 9'h184;
  localparam logic [ADDR_W-1:0] OFF_INT_ENABLE   = 9'h190;
  localparam logic [ADDR_W-1:0] OFF_INT_STATUS   = 9'h192;
  localparam logic [ADDR_W-1:0] OFF_TX_SPACE_REQ = 9'h19E;
  localparam logic [ADDR_W-1:0] OFF_QUEUE_DATA   = 9'h1C0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TXC_FLOW_BIT   = 3;
  localparam int TXC_PAD_BIT    = 2;
  localparam int TXC_CRC_BIT    = 1;
  localparam int TXC_EN_BIT     = 0;
  localparam int TXC_CSUM_LO    = 5;
  localparam int TXC_CSUM_HI    = 8;
  localparam int TXQ_ENQ_BIT    = 0;
  localparam int TXQ_SPACE_BIT  = 1;
  localparam int RXQ_DMA_BIT    = 3;
  localparam int PTR_AUTOINC    = 14;
  localparam int INT_TX_BIT     = 14;
  localparam int INT_SPACE_BIT  = 6;
  localparam int CW_IC_BIT      = 15;

  // ----------------------------------------------------------------
  // queue layout, sizes and reset values
  // ----------------------------------------------------------------
  localparam logic [FREE_W-1:0] TXQ_BYTES       = 13'h1800;
  localparam logic [FREE_W-1:0] FRAME_HDR_BYTES = 13'h0004;
  localparam logic [PTR_W-1:0]  HDR_CTL_PTR     = 11'h000;
  localparam logic [PTR_W-1:0]  HDR_LEN_PTR     = 11'h002;
  localparam logic [PTR_W-1:0]  PTR_STEP        = 11'h002;
  localparam logic [BC_W-1:0]   RX_MAX_BYTES    = 11'h7D0;
  localparam logic [1:0]        RX_IDX_STATUS   = 2'h0;
  localparam logic [1:0]        RX_IDX_LENGTH   = 2'h1;
  localparam logic [1:0]        RX_IDX_DATA     = 2'h2;
  localparam logic [DATA_W-1:0] REG16_RESET     = 16'h0000;

  // ----------------------------------------------------------------
  // host end AXI4-Lite register map
  // ----------------------------------------------------------------
  localparam logic [7:0] HOFF_CMD    = 8'h00;
  localparam logic [7:0] HOFF_WDATA  = 8'h04;
  localparam logic [7:0] HOFF_STATUS = 8'h08;
  localparam int         HCMD_WE_BIT = 9;
  localparam int         HCMD_GO_BIT = 31;
  localparam int         HST_BUSY    = 0;
  localparam int         HST_IRQ     = 1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] REG32_RESET = 32'h0000_0000;
endpackage
`default_nettype wire

// ---- testbench/host_tx_queue_manager_tb.sv ----
// bench driving the host end over AXI4-Lite, device end facing it
`default_nettype none
module host_tx_queue_manager_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import htq_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0, be_pin = 1'b0, tx_done = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [15:0] rx_stat = 16'h1234, rx_len = 16'h0900, rx_word = 16'hBEEF;
  logic        awready, wready, bvalid, arready, rvalid, f_valid, rx_rd;
  int          n_rx_rd = 0;
  logic [1:0]  bresp, rresp, resp_q;
  logic [31:0] rdata, rd_q;
  logic [15:0] ctl_out;
  logic [5:0]  f_id;
  logic [10:0] f_len;
  int          err_total = 0;
  int          n_checks = 0;
  htq_bus_if htq_bus_if_i ();
  htq_host htq_host_i (
    .aclk(aclk), .aresetn(aresetn), .bus(htq_bus_if_i.host),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  htq_device htq_device_i (
    .aclk(aclk), .aresetn(aresetn), .bus(htq_bus_if_i.dev), .big_endian_pin(be_pin),
    .mac_tx_done(tx_done), .rx_status(rx_stat), .rx_length(rx_len), .rx_data(rx_word),
    .tx_control(ctl_out), .tx_frame_valid(f_valid), .tx_frame_id(f_id),
    .tx_byte_count(f_len), .rx_word_read(rx_rd));
  htq_bus_sva htq_bus_sva_i (
    .aclk(aclk), .aresetn(aresetn), .req(htq_bus_if_i.req), .we(htq_bus_if_i.we),
    .addr(htq_bus_if_i.addr), .wdata(htq_bus_if_i.wdata), .rdata(htq_bus_if_i.rdata),
    .ack(htq_bus_if_i.ack), .irq(htq_bus_if_i.irq));
  // 100 MHz clock
  always #5 aclk = ~aclk;
  // counts data-word pulses from the receive side
  always @(posedge aclk) begin
    if (rx_rd) begin
      n_rx_rd <= n_rx_rd + 1;
    end
  end
  // ------------
  // bus tasks
  // ------------
  // handshakes taken at the rising edge; the trailing edge keeps back-to-back calls
  // from driving one signal twice in a time step
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic b_hit;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      b_hit = bvalid;
      resp_q = bresp;
    end while (!b_hit);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic r_hit;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      r_hit = rvalid;
      rd_q = rdata;
      resp_q = rresp;
    end while (!r_hit);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // a new command is dropped while busy, so every access waits here
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      axi_rd(HOFF_STATUS);
      n++;
    end while (rd_q[HST_BUSY] !== 1'b0 && n < 50);
    // a transfer that never finishes counts against the run
    if (rd_q[HST_BUSY] !== 1'b0) begin
      err_total++;
      $display("wrong value busy expected 0 seen %b", rd_q[HST_BUSY]);
    end
  endtask
  task automatic dwr(input logic [8:0] a, input logic [15:0] d);
    axi_wr(HOFF_WDATA, {16'h0000, d});
    axi_wr(HOFF_CMD, {1'b1, 21'h000000, 1'b1, a});
    wait_idle();
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic dchk(input logic [8:0] a, input logic [15:0] e, input string nm);
    axi_wr(HOFF_CMD, {1'b1, 21'h000000, 1'b0, a});
    wait_idle();
    chk(nm, e, rd_q[31:16]);
  endtask
  task automatic mac_done();
    tx_done <= 1'b1;
    @(posedge aclk);
    tx_done <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ------------
  // tests
  // ------------
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    dchk(OFF_TX_FREE_MEM, 16'h1800, "free");
    dwr(OFF_TX_CONTROL, 16'h01EF);
    dchk(OFF_TX_CONTROL, 16'h01EF, "control");
    chk("control pins", 16'h01EF, ctl_out);
    dchk(9'h000, 16'h0000, "unmapped");
    axi_rd(8'h0C);
    chk("axi resp", {14'h0000, RESP_SLVERR}, {14'h0000, resp_q});
    axi_wr(8'h0C, 32'h0000_0000);
    chk("axi bresp", {14'h0000, RESP_SLVERR}, {14'h0000, resp_q});
    $display("register test done");
    dwr(OFF_RX_QUEUE_CMD, 16'h0008);
    dwr(OFF_TX_DATA_PTR, 16'h4000);
    dwr(OFF_QUEUE_DATA, 16'h802A);
    dwr(OFF_QUEUE_DATA, 16'h0041);
    dchk(OFF_TX_DATA_PTR, 16'h4004, "pointer");
    chk("frame id", 16'h002A, {10'h000, f_id});
    chk("byte count", 16'h0041, {5'h00, f_len});
    dwr(OFF_INT_ENABLE, 16'h4000);
    dwr(OFF_TX_QUEUE_CMD, 16'h0001);
    chk("frame valid", 16'h0001, {15'h0000, f_valid});
    dchk(OFF_TX_FREE_MEM, 16'h17B8, "free");
    dwr(OFF_TX_QUEUE_CMD, 16'h0001);
    dchk(OFF_TX_FREE_MEM, 16'h17B8, "free");
    dchk(OFF_TX_QUEUE_CMD, 16'h0001, "enqueue");
    mac_done();
    dchk(OFF_TX_QUEUE_CMD, 16'h0000, "enqueue");
    dchk(OFF_TX_FREE_MEM, 16'h1800, "free");
    chk("irq", 16'h0001, {15'h0000, htq_bus_if_i.irq});
    dchk(OFF_INT_STATUS, 16'h4000, "status");
    dwr(OFF_INT_STATUS, 16'hFFFF);
    chk("irq", 16'h0000, {15'h0000, htq_bus_if_i.irq});
    $display("enqueue test done");
    dwr(OFF_TX_QUEUE_CMD, 16'h0001);
    dwr(OFF_TX_SPACE_REQ, 16'h0600);
    dchk(OFF_TX_SPACE_REQ, 16'h0600, "space req");
    dwr(OFF_TX_QUEUE_CMD, 16'h0002);
    dchk(OFF_TX_QUEUE_CMD, 16'h0003, "watch");
    dchk(OFF_INT_STATUS, 16'h0000, "status");
    dwr(OFF_INT_ENABLE, 16'h0000);
    mac_done();
    dchk(OFF_TX_QUEUE_CMD, 16'h0000, "watch");
    dchk(OFF_INT_STATUS, 16'h4040, "status");
    chk("irq", 16'h0000, {15'h0000, htq_bus_if_i.irq});
    dwr(OFF_INT_ENABLE, 16'h0040);
    chk("irq", 16'h0001, {15'h0000, htq_bus_if_i.irq});
    dwr(OFF_INT_STATUS, 16'h0040);
    dchk(OFF_INT_STATUS, 16'h4000, "status");
    chk("irq", 16'h0000, {15'h0000, htq_bus_if_i.irq});
    $display("space test done");
    dwr(OFF_RX_QUEUE_CMD, 16'h0000);
    dwr(OFF_RX_QUEUE_CMD, 16'h0008);
    dchk(OFF_QUEUE_DATA, 16'h1234, "rx status");
    dchk(OFF_QUEUE_DATA, 16'h07D0, "rx length");
    dchk(OFF_QUEUE_DATA, 16'hBEEF, "rx data");
    chk("rx reads", 16'h0001, n_rx_rd[15:0]);
    be_pin <= 1'b1;
    dwr(OFF_RX_QUEUE_CMD, 16'h0000);
    dwr(OFF_RX_QUEUE_CMD, 16'h0008);
    dchk(OFF_QUEUE_DATA, 16'h3412, "rx status");
    $display("receive test done");
    give_verdict();
  end
  // cuts a hang short, far beyond the few hundred cycles the tests need
  initial begin
    #300000;
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire

// ---- testbench/htq_bus_sva.sv ----
// checker for the bus between the host end and the device end
`default_nettype none
module htq_bus_sva (
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic                       req,
  input wire logic                       we,
  input wire logic [htq_pkg::ADDR_W-1:0] addr,
  input wire logic [htq_pkg::DATA_W-1:0] wdata,
  input wire logic [htq_pkg::DATA_W-1:0] rdata,
  input wire logic                       ack,
  input wire logic                       irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import htq_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [15:0] ctl_q;
  logic [15:0] ien_q;
  // ------------
  // write shadows
  // ------------
  // readback is judged against what was written, reserved bits masked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q <= '0;
      ien_q <= '0;
    end else if (req && we && addr == OFF_TX_CONTROL) begin
      ctl_q <= wdata;
    end else if (req && we && addr == OFF_INT_ENABLE) begin
      ien_q <= wdata;
    end
  end
  // single bus accesses to one offset
  sequence rd_of(logic [8:0] a);
    req && !we && addr == a;
  endsequence
  sequence wr_of(logic [8:0] a, logic [15:0] d);
    req && we && addr == a && wdata == d;
  endsequence
  // ------------
  // assertions
  // ------------
  ack_next_a: assert property (req |=> ack)
    else $error("no ack after request");
  ack_cause_a: assert property (ack |-> $past(req))
    else $error("ack without request");
  req_gap_a: assert property (req |=> !req)
    else $error("request before ack");
  rdata_hold_a: assert property (!(req && !we) |=> $stable(rdata))
    else $error("read data moved");
  low_read_a: assert property (req && !we && addr < OFF_TX_CONTROL |=> rdata == '0)
    else $error("unmapped read not zero");
  ctl_back_a: assert property (rd_of(OFF_TX_CONTROL) |=> (rdata & 16'h01EF) == (ctl_q & 16'h01EF))
    else $error("control readback wrong");
  irq_gate_a: assert property (irq |-> (ien_q & 16'h4040) != '0)
    else $error("irq while masked");
  mask_off_a: assert property (wr_of(OFF_INT_ENABLE, 16'h0000) |-> ##2 !irq)
    else $error("irq after mask");
  stat_clear_a: assert property (wr_of(OFF_INT_STATUS, 16'hFFFF) |-> ##2 !irq)
    else $error("irq after clear");
endmodule
`default_nettype wire
